// ### baud_pkg.sv
// Constants shared by the baud rate generator and its serial engine
// What this block does
// - Each serial bit lasts a selectable 15 to 17 sub-bit ticks.
// - One sub-bit tick every divisor plus one cycles of the chosen base clock.
// - Selector codes 001 and 011 alternate two tick counts on successive bits.
// - 000=16, 001=16/17, 010=15, 011=15/16, 100=17 ticks per bit.
// - Frame: start, data 0..7, optional parity, one or two stop bits.
// - One tick and divisor setting times both transmit and receive bits.
// - Divisor 06 with selector 011 at 32.768 kHz gives 300 baud.
// - Receiver samples ticks 8, 7 and 6 of each bit and takes majority.
package baud_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  // Avalon register word offsets (byte address / 4)
  localparam logic [3:0] REG_CTRL_ONE = 4'h0;
  localparam logic [3:0] REG_CTRL_TWO = 4'h1;
  localparam logic [3:0] REG_DIVISOR = 4'h2;
  localparam logic [3:0] REG_TX_DATA = 4'h3;
  localparam logic [3:0] REG_RX_DATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  // serial_control_one fields
  localparam int C1_TX_EN = 0;
  localparam int C1_RX_EN = 1;
  localparam int C1_PAR_EN = 2;
  localparam int C1_PAR_ODD = 3;
  localparam int C1_STOP2 = 4;
  localparam int C1_BASE_LO = 5;
  localparam int C1_BASE_HI = 6;
  // serial_control_two fields
  localparam int C2_TSEL_LO = 0;
  localparam int C2_TSEL_HI = 2;
  // Status fields
  localparam int ST_TX_FULL = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_PAR_ERR = 3;
  localparam int ST_FRM_ERR = 4;
  localparam int ST_RX_OVR = 5;
  // Tick-count selector codes
  localparam logic [2:0] TSEL_16 = 3'h0;
  localparam logic [2:0] TSEL_16_17 = 3'h1;
  localparam logic [2:0] TSEL_15 = 3'h2;
  localparam logic [2:0] TSEL_15_16 = 3'h3;
  localparam logic [2:0] TSEL_17 = 3'h4;
  localparam logic [4:0] TICKS_15 = 5'h0F;
  localparam logic [4:0] TICKS_16 = 5'h10;
  localparam logic [4:0] TICKS_17 = 5'h11;
  // Down-counted tick index sample window
  localparam logic [4:0] SAMPLE_FIRST = 5'h08;
  localparam logic [4:0] SAMPLE_LAST = 5'h06;
  // Base clock prescale choices (clk/1, /2, /4, /8)
  localparam logic [2:0] PRE_MASK_1 = 3'h0;
  localparam logic [2:0] PRE_MASK_2 = 3'h1;
  localparam logic [2:0] PRE_MASK_4 = 3'h3;
  localparam logic [2:0] PRE_MASK_8 = 3'h7;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [2:0] TSEL_RESET = 3'h0;
  localparam int DATA_BITS = 8;
endpackage

// ### fifo_if.sv
// Handshake bundle between the register slave and the transmit FIFO
`timescale 1ns/10ps
interface fifo_if;
  logic [7:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_ready;
  modport fifo (
    input  in_data,
    input  in_valid,
    output in_ready,
    output out_data,
    output out_valid,
    input  out_ready
  );
  modport user (
    output in_data,
    output in_valid,
    input  in_ready,
    input  out_data,
    input  out_valid,
    output out_ready
  );
endinterface

// ### remote_serial_model.sv
// Behavioural far-side serial device: sends frames and decodes transmitted ones
`timescale 1ns/10ps
module remote_serial_model (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  input  int        lo_cyc_i,
  input  int        hi_cyc_i,
  input  wire logic par_en_i
);
  logic [7:0] rx_q [$];
  logic [7:0] sh;

  initial rxd_o = 1'b1;

  // Even bits get the lower count, so the start bit always does
  function automatic int width(input int k);
    return (k % 2 == 0) ? lo_cyc_i : hi_cyc_i;
  endfunction

  // Start, data LSB first, optional parity, stop, then idle high
  task automatic send_frame(input logic [7:0] d, input logic use_par, input logic par_bit,
                            input logic stop_v);
    logic [11:0] bits;
    bits = use_par ? {1'b1, stop_v, par_bit, d, 1'b0} : {2'b11, stop_v, d, 1'b0};
    for (int k = 0; k < 12; k++) begin
      rxd_o <= bits[k];
      repeat (width(k)) @(posedge clk_i);
    end
  endtask

  // Mid-bit sampling; stop bit is not judged here
  initial forever begin
    @(negedge txd_i);
    for (int k = 0; k < 9 + par_en_i; k++) begin
      repeat (width(k) / 2) @(posedge clk_i);
      if (k > 0 && k < 9) sh[k-1] = txd_i;
      repeat (width(k) - width(k) / 2) @(posedge clk_i);
    end
    rx_q.push_back(sh);
  end
endmodule

// ### sync_fifo.sv
// Parameterised synchronous FIFO with registered read data
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  fifo_if.fifo      port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [WIDTH-1:0] out_ff;
  logic             out_valid_ff;
  logic             push;
  logic             pop_mem;

  // Output register refills when empty or being drained
  assign pop_mem = (count_ff != '0) && (!out_valid_ff || port.out_ready);
  assign push = port.in_valid && port.in_ready;
  assign port.in_ready = (count_ff + (AW+1)'(out_valid_ff) != (AW+1)'(DEPTH));
  assign port.out_data = out_ff;
  assign port.out_valid = out_valid_ff;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= port.in_data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop_mem) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop_mem);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_ff <= '0;
      out_valid_ff <= 1'b0;
    end else if (pop_mem) begin
      out_ff <= mem[rd_ptr_ff];
      out_valid_ff <= 1'b1;
    end else if (port.out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule

// ### uart_baud_rate_generator.sv
// UART with programmable sub-bit tick baud generator and Avalon-MM registers
`timescale 1ns/10ps
module uart_baud_rate_generator (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rxd_i,
  output logic             txd_o
);
  typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP1, STOP2} frame_e;

  logic [7:0]  serial_control_one_ff;
  logic        tx_busy;
  logic [7:0]  baud_divisor_ff;
  logic [2:0]  tsel_ff;
  logic        ack_ff;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rx_data_ff;
  logic        rx_valid_ff;
  logic        par_err_ff;
  logic        frm_err_ff;
  logic        ovr_ff;
  logic        rx_done;
  logic        rx_pe;
  logic        rx_fe;
  logic [7:0]  rx_byte;

  fifo_if tx_q ();

  sync_fifo #(
    .WIDTH (baud_pkg::DATA_W),
    .DEPTH (baud_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .port     (tx_q.fifo)
  );

  // Ticks for a bit: alternate phase 0 gives the lower count
  function automatic logic [4:0] bit_ticks(input logic [2:0] sel, input logic phase);
    logic [4:0] t;
    t = baud_pkg::TICKS_16;
    case (sel)
      baud_pkg::TSEL_16:    t = baud_pkg::TICKS_16;
      baud_pkg::TSEL_16_17: t = phase ? baud_pkg::TICKS_17 : baud_pkg::TICKS_16;
      baud_pkg::TSEL_15:    t = baud_pkg::TICKS_15;
      baud_pkg::TSEL_15_16: t = phase ? baud_pkg::TICKS_16 : baud_pkg::TICKS_15;
      baud_pkg::TSEL_17:    t = baud_pkg::TICKS_17;
      default:              t = baud_pkg::TICKS_16;
    endcase
    return t;
  endfunction

  // Bus slave: one wait state; writes land at the end of the cycle after it
  assign wr_hit = avs_write_i && ack_ff;
  assign rd_hit = avs_read_i && !ack_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_ff);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_control_one_ff <= '0;
      tsel_ff <= baud_pkg::TSEL_RESET;
      baud_divisor_ff <= baud_pkg::DIVISOR_RESET;
    end else if (wr_hit && avs_byteenable_i[0]) begin
      case (avs_address_i)
        baud_pkg::REG_CTRL_ONE: serial_control_one_ff <= avs_writedata_i[7:0];
        baud_pkg::REG_CTRL_TWO: tsel_ff <= avs_writedata_i[baud_pkg::C2_TSEL_HI:baud_pkg::C2_TSEL_LO];
        baud_pkg::REG_DIVISOR:  baud_divisor_ff <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  assign tx_q.in_data = avs_writedata_i[7:0];
  // Writes to a full FIFO are dropped; status shows full beforehand
  assign tx_q.in_valid = wr_hit && avs_byteenable_i[0] && (avs_address_i == baud_pkg::REG_TX_DATA);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= '0;
    end else if (rd_hit) begin
      case (avs_address_i)
        baud_pkg::REG_CTRL_ONE: avs_readdata_o <= {24'h000000, serial_control_one_ff};
        baud_pkg::REG_CTRL_TWO: avs_readdata_o <= {29'h00000000, tsel_ff};
        baud_pkg::REG_DIVISOR:  avs_readdata_o <= {24'h000000, baud_divisor_ff};
        baud_pkg::REG_RX_DATA:  avs_readdata_o <= {24'h000000, rx_data_ff};
        baud_pkg::REG_STATUS:   avs_readdata_o <= {26'h0000000, ovr_ff, frm_err_ff, par_err_ff,
                                                   tx_busy, rx_valid_ff, !tx_q.in_ready};
        default:                avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Base clock prescaler and divisor: one sub-bit tick per (divisor+1) base pulses
  logic [2:0] pre_ff;
  logic [2:0] pre_mask;
  logic       base_en;
  logic [7:0] div_cnt_ff;
  logic       tick_ff;

  always_comb begin
    case (serial_control_one_ff[baud_pkg::C1_BASE_HI:baud_pkg::C1_BASE_LO])
      2'h0:    pre_mask = baud_pkg::PRE_MASK_1;
      2'h1:    pre_mask = baud_pkg::PRE_MASK_2;
      2'h2:    pre_mask = baud_pkg::PRE_MASK_4;
      default: pre_mask = baud_pkg::PRE_MASK_8;
    endcase
  end
  assign base_en = ((pre_ff & pre_mask) == pre_mask);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (base_en) begin
        if (div_cnt_ff >= baud_divisor_ff) begin
          div_cnt_ff <= '0;
          tick_ff <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 1'b1;
        end
      end
    end
  end

  // Transmitter: shares tick and selector with the receiver
  frame_e     tx_st_ff;
  logic [4:0] tx_tcnt_ff;
  logic       tx_phase_ff;
  logic [7:0] tx_sh_ff;
  logic [2:0] tx_bit_ff;
  logic       tx_par_ff;
  logic       tx_bit_end;
  frame_e     tx_next;

  assign tx_busy = (tx_st_ff != IDLE);
  assign tx_bit_end = tick_ff && (tx_tcnt_ff == 5'h01);
  assign tx_q.out_ready = !tx_busy && serial_control_one_ff[baud_pkg::C1_TX_EN];

  // Next frame element after the current bit
  function automatic frame_e next_elem(input frame_e s, input logic last_data,
                                       input logic par_en, input logic two_stop);
    frame_e n;
    n = IDLE;
    case (s)
      START:   n = DATA;
      DATA:    n = !last_data ? DATA : (par_en ? PARITY : STOP1);
      PARITY:  n = STOP1;
      STOP1:   n = two_stop ? STOP2 : IDLE;
      default: n = IDLE;
    endcase
    return n;
  endfunction

  assign tx_next = next_elem(tx_st_ff, tx_bit_ff == 3'h7,
                             serial_control_one_ff[baud_pkg::C1_PAR_EN],
                             serial_control_one_ff[baud_pkg::C1_STOP2]);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_ff <= IDLE;
      tx_tcnt_ff <= '0;
      tx_phase_ff <= 1'b0;
      tx_sh_ff <= '0;
      tx_bit_ff <= '0;
      tx_par_ff <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      case (tx_st_ff)
        IDLE: begin
          txd_o <= 1'b1;
          if (tx_q.out_valid && tx_q.out_ready) begin
            tx_st_ff <= START;
            tx_sh_ff <= tx_q.out_data;
            tx_par_ff <= ^tx_q.out_data ^ serial_control_one_ff[baud_pkg::C1_PAR_ODD];
            tx_bit_ff <= '0;
            tx_phase_ff <= 1'b1;
            tx_tcnt_ff <= bit_ticks(tsel_ff, 1'b0);
            txd_o <= 1'b0;
          end
        end
        default: begin
          if (tick_ff) begin
            tx_tcnt_ff <= tx_tcnt_ff - 1'b1;
          end
          if (tx_bit_end) begin
            tx_st_ff <= tx_next;
            tx_phase_ff <= !tx_phase_ff;
            tx_tcnt_ff <= bit_ticks(tsel_ff, tx_phase_ff);
            if (tx_st_ff == DATA) begin
              tx_bit_ff <= tx_bit_ff + 1'b1;
              tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            end
            case (tx_next)
              DATA:    txd_o <= (tx_st_ff == START) ? tx_sh_ff[0] : tx_sh_ff[1];
              PARITY:  txd_o <= tx_par_ff;
              default: txd_o <= 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  // Receiver input: three flops, change counted when last two agree
  logic [2:0] rx_sync_ff;
  logic       rx_in_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sync_ff <= 3'h7;
      rx_in_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], rxd_i};
      if (rx_sync_ff[1] == rx_sync_ff[2]) begin
        rx_in_ff <= rx_sync_ff[2];
      end
    end
  end

  frame_e     rx_st_ff;
  logic [4:0] rx_tcnt_ff;
  logic       rx_phase_ff;
  logic [1:0] rx_votes_ff;
  logic [7:0] rx_sh_ff;
  logic [2:0] rx_bit_ff;
  logic       rx_par_ff;
  logic       rx_prev_ff;
  logic       rx_bit;
  logic       rx_in_win;
  frame_e     rx_next;

  assign rx_in_win = (rx_tcnt_ff <= baud_pkg::SAMPLE_FIRST) &&
                     (rx_tcnt_ff >= baud_pkg::SAMPLE_LAST);
  assign rx_bit = rx_votes_ff[1];
  assign rx_next = next_elem(rx_st_ff, rx_bit_ff == 3'h7,
                             serial_control_one_ff[baud_pkg::C1_PAR_EN],
                             serial_control_one_ff[baud_pkg::C1_STOP2]);
  assign rx_byte = rx_sh_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_ff <= IDLE;
      rx_tcnt_ff <= '0;
      rx_phase_ff <= 1'b0;
      rx_votes_ff <= '0;
      rx_sh_ff <= '0;
      rx_bit_ff <= '0;
      rx_par_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_done <= 1'b0;
      rx_pe <= 1'b0;
      rx_fe <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_prev_ff <= rx_in_ff;
      case (rx_st_ff)
        IDLE: begin
          if (serial_control_one_ff[baud_pkg::C1_RX_EN] && rx_prev_ff && !rx_in_ff) begin
            rx_st_ff <= START;
            rx_phase_ff <= 1'b1;
            rx_tcnt_ff <= bit_ticks(tsel_ff, 1'b0) - 5'h01;
            rx_votes_ff <= '0;
            rx_bit_ff <= '0;
            rx_par_ff <= serial_control_one_ff[baud_pkg::C1_PAR_ODD];
          end
        end
        default: begin
          if (tick_ff) begin
            // Majority of three samples at ticks 8..6 regardless of count
            if (rx_in_win && rx_in_ff) begin
              rx_votes_ff <= rx_votes_ff + 2'h1;
            end
            if (rx_tcnt_ff != '0) begin
              rx_tcnt_ff <= rx_tcnt_ff - 1'b1;
            end else begin
              rx_votes_ff <= '0;
              rx_phase_ff <= !rx_phase_ff;
              rx_tcnt_ff <= bit_ticks(tsel_ff, rx_phase_ff) - 5'h01;
              rx_st_ff <= rx_next;
              case (rx_st_ff)
                START: begin
                  // Noise on the start bit aborts and waits for a new edge
                  if (rx_bit) begin
                    rx_st_ff <= IDLE;
                  end
                end
                DATA: begin
                  rx_sh_ff <= {rx_bit, rx_sh_ff[7:1]};
                  rx_par_ff <= rx_par_ff ^ rx_bit;
                  rx_bit_ff <= rx_bit_ff + 1'b1;
                end
                PARITY: rx_pe <= (rx_bit != rx_par_ff);
                STOP1: begin
                  rx_fe <= !rx_bit;
                  if (!serial_control_one_ff[baud_pkg::C1_PAR_EN]) begin
                    rx_pe <= 1'b0;
                  end
                  // Second stop bit is timed but not checked
                  rx_done <= !serial_control_one_ff[baud_pkg::C1_STOP2];
                end
                STOP2: rx_done <= 1'b1;
                default: ;
              endcase
            end
          end
        end
      endcase
    end
  end

  // Receive buffer and sticky flags; set wins over read clear
  logic rx_read;
  assign rx_read = rd_hit && (avs_address_i == baud_pkg::REG_RX_DATA);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else if (rx_done) begin
      if (rx_valid_ff && !rx_read) begin
        ovr_ff <= 1'b1;
      end else begin
        rx_data_ff <= rx_byte;
        rx_valid_ff <= 1'b1;
        par_err_ff <= rx_pe;
        frm_err_ff <= rx_fe;
      end
    end else if (rx_read) begin
      rx_valid_ff <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end
  end
endmodule

// ### uart_baud_rate_generator_sva.sv
// Bus handshake and serial timing checks on the top ports
`timescale 1ns/10ps
module uart_baud_rate_generator_sva (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        rxd_i,
  input wire logic        txd_o
);
  logic [7:0] run_ff;
  logic       prev_txd_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Saturating run length of the serial output level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_ff      <= 8'h00;
      prev_txd_ff <= 1'b1;
    end else begin
      prev_txd_ff <= txd_o;
      if (txd_o != prev_txd_ff) run_ff <= 8'h01;
      else if (run_ff != 8'hFF) run_ff <= run_ff + 8'h01;
    end
  end

  property p_wait_answer;
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("waitrequest late");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause;
    !avs_waitrequest_o |-> (avs_read_i || avs_write_i) && $past(avs_read_i || avs_write_i);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_unmapped_zero;
    avs_read_i && !avs_waitrequest_o && avs_address_i > baud_pkg::REG_STATUS
      |-> avs_readdata_o == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_upper_zero;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_rdata_hold;
    $changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_min_bit;
    txd_o != prev_txd_ff |-> run_ff >= 8'h0F;
  endproperty
  a_min_bit: assert property (p_min_bit) else $error("serial bit too short");
  property p_idle_busy;
    avs_read_i && !avs_waitrequest_o && avs_address_i == baud_pkg::REG_STATUS
      && !avs_readdata_o[baud_pkg::ST_TX_BUSY] |-> $past(txd_o);
  endproperty
  a_idle_busy: assert property (p_idle_busy) else $error("line low while idle");

  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
  c_start: cover property ($fell(txd_o));
endmodule

bind uart_baud_rate_generator uart_baud_rate_generator_sva sva_inst (
  .clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rxd_i, .txd_o
);

// ### uart_baud_rate_generator_tb.sv
// Self-checking bench for the baud generator UART
`timescale 1ns/10ps
module uart_baud_rate_generator_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        rxd;
  logic        txd;
  logic        txd_q = 1'b1;
  logic        par_en = 1'b0;
  int          lo_cyc = 16;
  int          hi_cyc = 16;
  int          run = 0;
  int          w_q [$];
  int          errors = 0;
  int          samples_checked = 0;

  always #50 clk = ~clk;

  uart_baud_rate_generator uart_baud_rate_generator_inst (
    .clk_i(clk), .arst_n_i(arst_n), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .rxd_i(rxd), .txd_o(txd)
  );
  remote_serial_model remote_serial_model_inst (
    .clk_i(clk), .txd_i(txd), .rxd_o(rxd), .lo_cyc_i(lo_cyc), .hi_cyc_i(hi_cyc),
    .par_en_i(par_en)
  );

  // Records the length of every level run on the serial output
  always @(posedge clk) begin
    if (txd !== txd_q) begin
      w_q.push_back(run);
      run = 1;
    end else run++;
    txd_q = txd;
  end

  task automatic close_out();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] rd);
    int n;
    addr <= a;
    wdata <= d;
    be <= b;
    wr_en <= we;
    rd_en <= !we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 100) begin
      errors++;
      close_out();
    end
    @(posedge clk);
  endtask

  task automatic wait_status(input int b, input logic v, output logic [31:0] rd);
    int n;
    int hits = 0;
    n = 0;
    do begin
      bus(1'b0, baud_pkg::REG_STATUS, 32'h0, 4'hF, rd);
      hits = rd[b] === v ? hits + 1 : 0;
      n++;
    end while (hits < 2 && n < 3000);
    if (n >= 3000) begin
      errors++;
      close_out();
    end
  endtask

  task automatic reg_reset();
    logic [31:0] rd;
    bus(1'b0, baud_pkg::REG_CTRL_ONE, 32'h0, 4'hF, rd);
    check(rd, 32'h0, "ctrl one reset");
    bus(1'b0, baud_pkg::REG_CTRL_TWO, 32'h0, 4'hF, rd);
    check(rd, {29'h0, baud_pkg::TSEL_RESET}, "ctrl two reset");
    bus(1'b1, baud_pkg::REG_DIVISOR, 32'hA5, 4'h0, rd);
    bus(1'b0, baud_pkg::REG_DIVISOR, 32'h0, 4'hF, rd);
    check(rd, {24'h0, baud_pkg::DIVISOR_RESET}, "divisor without byte enable");
    bus(1'b1, baud_pkg::REG_DIVISOR, 32'hFFFF_FFA5, 4'hF, rd);
    bus(1'b1, 4'hE, 32'h5A, 4'hF, rd);
    bus(1'b0, baud_pkg::REG_DIVISOR, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_00A5, "divisor read back");
    bus(1'b0, 4'hE, 32'h0, 4'hF, rd);
    check(rd, 32'h0, "unmapped read");
  endtask

  // Sends 0x55 twice so every bit boundary is an edge, then checks widths
  task automatic tx_timing(input logic [2:0] sel, input logic [7:0] div, input logic [1:0] base);
    logic [31:0] rd;
    int m;
    int n;
    m = (div + 1) << base;
    case (sel)
      baud_pkg::TSEL_16_17: begin lo_cyc = 16 * m; hi_cyc = 17 * m; end
      baud_pkg::TSEL_15: begin lo_cyc = 15 * m; hi_cyc = 15 * m; end
      baud_pkg::TSEL_15_16: begin lo_cyc = 15 * m; hi_cyc = 16 * m; end
      baud_pkg::TSEL_17: begin lo_cyc = 17 * m; hi_cyc = 17 * m; end
      default: begin lo_cyc = 16 * m; hi_cyc = 16 * m; end
    endcase
    par_en = 1'b0;
    bus(1'b1, baud_pkg::REG_CTRL_TWO, {29'h0, sel}, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_DIVISOR, {24'h0, div}, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_CTRL_ONE, {25'h0, base, 5'h03}, 4'hF, rd);
    w_q.delete();
    bus(1'b1, baud_pkg::REG_TX_DATA, 32'h55, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_TX_DATA, 32'h55, 4'hF, rd);
    for (n = 0; w_q.size() < 20 && n < 5000; n++) @(posedge clk);
    if (n >= 5000) begin
      errors++;
      close_out();
    end
    // Start width only exact when the tick runs every clock
    for (int k = 0; k < 9; k++) begin
      if (k > 0 || m == 1) check(w_q[1+k], k % 2 ? hi_cyc : lo_cyc, "first frame bit");
      if (k > 0 || m == 1) check(w_q[11+k], k % 2 ? hi_cyc : lo_cyc, "second frame bit");
    end
    wait_status(baud_pkg::ST_TX_BUSY, 1'b0, rd);
    check(remote_serial_model_inst.rx_q.size(), 2, "frames received");
    while (remote_serial_model_inst.rx_q.size() > 0)
      check(remote_serial_model_inst.rx_q.pop_front(), 8'h55, "received byte");
  endtask

  // Same timing setting receives good, bad parity and bad stop frames
  task automatic rx_frames();
    logic [31:0] rd;
    logic [7:0]  d [3] = '{8'hA3, 8'h5C, 8'hF0};
    lo_cyc = 15;
    hi_cyc = 16;
    par_en = 1'b1;
    bus(1'b1, baud_pkg::REG_CTRL_TWO, {29'h0, baud_pkg::TSEL_15_16}, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_DIVISOR, 32'h0, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_CTRL_ONE, 32'h07, 4'hF, rd);
    for (int i = 0; i < 3; i++) begin
      remote_serial_model_inst.send_frame(d[i], 1'b1, ^d[i] ^ (i == 1), i != 2);
      wait_status(baud_pkg::ST_RX_VALID, 1'b1, rd);
      check(rd[baud_pkg::ST_PAR_ERR], i == 1, "parity flag");
      check(rd[baud_pkg::ST_FRM_ERR], i == 2, "framing flag");
      bus(1'b0, baud_pkg::REG_RX_DATA, 32'h0, 4'hF, rd);
      check(rd, {24'h0, d[i]}, "received data");
      bus(1'b0, baud_pkg::REG_STATUS, 32'h0, 4'hF, rd);
      check(rd[5:1], 5'h00, "flags cleared by data read");
    end
  endtask

  // Shifter plus eight FIFO words take nine bytes; the tenth is dropped
  task automatic fifo_fill();
    logic [31:0] rd;
    lo_cyc = 16;
    hi_cyc = 16;
    par_en = 1'b0;
    bus(1'b1, baud_pkg::REG_CTRL_TWO, {29'h0, baud_pkg::TSEL_16}, 4'hF, rd);
    bus(1'b1, baud_pkg::REG_CTRL_ONE, 32'h03, 4'hF, rd);
    for (int i = 0; i < 10; i++) bus(1'b1, baud_pkg::REG_TX_DATA, 32'h30 + i, 4'hF, rd);
    bus(1'b0, baud_pkg::REG_STATUS, 32'h0, 4'hF, rd);
    check(rd[baud_pkg::ST_TX_FULL], 1'b1, "fifo full");
    wait_status(baud_pkg::ST_TX_BUSY, 1'b0, rd);
    check(rd[baud_pkg::ST_TX_FULL], 1'b0, "fifo empty");
    check(remote_serial_model_inst.rx_q.size(), 9, "bytes sent");
    for (int i = 0; i < 9; i++)
      check(remote_serial_model_inst.rx_q.pop_front(), 8'h30 + i, "fifo order");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    check(txd, 1'b1, "line idle in reset");
    check(wait_req, 1'b1, "waitrequest in reset");
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    reg_reset();
    tx_timing(baud_pkg::TSEL_16, 8'h00, 2'h0);
    tx_timing(baud_pkg::TSEL_16_17, 8'h00, 2'h0);
    tx_timing(baud_pkg::TSEL_15, 8'h00, 2'h0);
    tx_timing(baud_pkg::TSEL_15_16, 8'h00, 2'h0);
    tx_timing(baud_pkg::TSEL_17, 8'h00, 2'h0);
    tx_timing(baud_pkg::TSEL_16_17, 8'h01, 2'h1);
    tx_timing(baud_pkg::TSEL_15_16, 8'h06, 2'h0);
    rx_frames();
    fifo_fill();
    close_out();
  end
endmodule
